//--- rtl/host_serial_slave_memory_port.sv
// device end: serial slave port into the external data memory space
//
// Functional notes
// - deselected: reset, float, ignore
// - start at first rising clock
// - address, command, status, data
// - host raises select to end
// - multi-byte: skip x0000000 commands
// - single byte: command, interrupt
// - command msb: read or write
// - no address in single byte
// - status of previous frame out
// - error: not ready, partial byte
// - address steps per data byte
// - eight clocks per byte
// - protect: writes only 0x400..0x40F
// - host asks processor instead
// - protect on config bit 3
// - config bit 4 clear disables
// - reset restores serial pins
// - 16-bit external memory space
// - quiet writes skip notification
// - flash read and program (not implemented: the port reaches only the 16-bit data memory)
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
module host_serial_slave_memory_port (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    host_link_if.device      link,
    input  wire logic [7:0]  config_byte,
    input  wire logic        device_ready,
    output logic      [15:0] mem_addr,
    output logic      [7:0]  mem_wdata,
    output logic             mem_we,
    output logic             mem_re,
    input  wire logic [7:0]  mem_rdata,
    output logic      [7:0]  host_command_byte,
    output logic      [7:0]  host_link_status,
    output logic             command_irq,
    output logic             write_irq,
    output logic             serial_pin_mode
);

    function automatic logic write_allowed(input logic prot, input logic [15:0] a);
        write_allowed = !prot || (a >= host_link_pkg::OPEN_LO && a <= host_link_pkg::OPEN_HI);
    endfunction

    ////////////////////
    // input synchronisers and edge detection

    logic       sel_s1_ff, sel_s2_ff, sel_s3_ff;
    logic       ck_s1_ff, ck_s2_ff, ck_s3_ff;
    logic       di_s1_ff, di_s2_ff;
    logic       enabled;
    logic       active;
    logic       rise;
    logic       fall;
    logic       frame_end;
    logic       byte_done;
    logic [7:0] byte_in;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_s1_ff <= 1'b1;
            sel_s2_ff <= 1'b1;
            sel_s3_ff <= 1'b1;
            ck_s1_ff  <= 1'b0;
            ck_s2_ff  <= 1'b0;
            ck_s3_ff  <= 1'b0;
            di_s1_ff  <= 1'b0;
            di_s2_ff  <= 1'b0;
        end else begin
            sel_s1_ff <= link.select_n;
            sel_s2_ff <= sel_s1_ff;
            sel_s3_ff <= sel_s2_ff;
            ck_s1_ff  <= link.sclk;
            ck_s2_ff  <= ck_s1_ff;
            ck_s3_ff  <= ck_s2_ff;
            di_s1_ff  <= link.mosi;
            di_s2_ff  <= di_s1_ff;
        end
    end

    assign enabled   = config_byte[host_link_pkg::CFG_ENABLE_BIT];
    assign active    = !sel_s2_ff && enabled;
    assign rise      = active && ck_s2_ff && !ck_s3_ff;
    assign fall      = active && !ck_s2_ff && ck_s3_ff;
    assign frame_end = !sel_s3_ff && (sel_s2_ff || !enabled);

    ////////////////////
    // bit and byte framing

    logic [2:0]  bit_cnt_ff;
    logic [2:0]  byte_cnt_ff;
    logic [7:0]  rx_ff;
    logic [7:0]  first_byte_ff;
    logic [7:0]  cmd_byte_ff;
    logic [15:0] addr_ff;
    logic        parity_ff;
    logic        not_ready_ff;

    assign byte_in   = {rx_ff[6:0], di_s2_ff};
    assign byte_done = rise && bit_cnt_ff == host_link_pkg::BIT_LAST;

    always_ff @(posedge aclk) begin
        if (!aresetn || !active) begin
            bit_cnt_ff  <= 3'h0;
            byte_cnt_ff <= 3'h0;
            rx_ff       <= 8'h00;
        end else if (rise) begin
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
            rx_ff      <= byte_in;
            if (byte_done && byte_cnt_ff != host_link_pkg::BYTE_SAT) begin
                byte_cnt_ff <= byte_cnt_ff + 3'h1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || !active) begin
            parity_ff    <= 1'b0;
            not_ready_ff <= 1'b0;
        end else begin
            if (rise && di_s2_ff) begin
                parity_ff <= !parity_ff;
            end
            if (!device_ready) begin
                not_ready_ff <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            first_byte_ff <= 8'h00;
            cmd_byte_ff   <= 8'h00;
            addr_ff       <= 16'h0000;
        end else if (byte_done) begin
            if (byte_cnt_ff == host_link_pkg::BYTE_ADDR_HI) begin
                first_byte_ff <= byte_in;
                addr_ff       <= {byte_in, addr_ff[7:0]};
            end else if (byte_cnt_ff == host_link_pkg::BYTE_ADDR_HI + 3'h1) begin
                addr_ff <= {addr_ff[15:8], byte_in};
            end else if (byte_cnt_ff == host_link_pkg::BYTE_CMD) begin
                cmd_byte_ff <= byte_in;
                if (byte_in[host_link_pkg::CMD_RW_BIT]) begin
                    addr_ff <= addr_ff + 16'h0001;
                end
            end else if (byte_cnt_ff >= host_link_pkg::BYTE_DATA0 || is_read) begin
                addr_ff <= addr_ff + 16'h0001;
            end
        end
    end

    ////////////////////
    // memory access

    logic        is_read;
    logic        rd_pend_ff;
    logic [7:0]  rd_data_ff;

    assign is_read = cmd_byte_ff[host_link_pkg::CMD_RW_BIT];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mem_addr  <= 16'h0000;
            mem_wdata <= 8'h00;
            mem_we    <= 1'b0;
            mem_re    <= 1'b0;
            write_irq <= 1'b0;
        end else begin
            mem_we    <= 1'b0;
            mem_re    <= 1'b0;
            write_irq <= 1'b0;
            if (byte_done && byte_cnt_ff == host_link_pkg::BYTE_CMD && byte_in[host_link_pkg::CMD_RW_BIT]) begin
                mem_addr <= addr_ff;
                mem_re   <= 1'b1;
            end else if (byte_done && byte_cnt_ff >= host_link_pkg::BYTE_STATUS && is_read) begin
                mem_addr <= addr_ff;
                mem_re   <= 1'b1;
            end else if (byte_done && byte_cnt_ff >= host_link_pkg::BYTE_DATA0 && !is_read) begin
                if (write_allowed(config_byte[host_link_pkg::CFG_PROTECT_BIT], addr_ff)) begin
                    mem_addr  <= addr_ff;
                    mem_wdata <= byte_in;
                    mem_we    <= 1'b1;
                    write_irq <= !cmd_byte_ff[host_link_pkg::CMD_QUIET_BIT];
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_pend_ff <= 1'b0;
            rd_data_ff <= 8'h00;
        end else begin
            rd_pend_ff <= mem_re;
            if (rd_pend_ff) begin
                rd_data_ff <= mem_rdata;
            end
        end
    end

    ////////////////////
    // serial output

    logic [7:0] tx_ff;
    logic       miso_ff;
    logic       oe_n_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn || !active) begin
            tx_ff <= 8'h00;
        end else if (byte_done && byte_cnt_ff == host_link_pkg::BYTE_CMD) begin
            tx_ff <= host_link_status;
        end else if (byte_done && byte_cnt_ff >= host_link_pkg::BYTE_STATUS && is_read) begin
            tx_ff <= rd_data_ff;
        end else if (fall) begin
            tx_ff <= {tx_ff[6:0], 1'b0};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || !active) begin
            miso_ff <= 1'b0;
            oe_n_ff <= 1'b1;
        end else begin
            oe_n_ff <= 1'b0;
            if (fall) begin
                miso_ff <= tx_ff[7];
            end
        end
    end

    assign link.miso      = miso_ff;
    assign link.miso_oe_n = oe_n_ff;

    ////////////////////
    // end of frame: command register, status, interrupt

    logic single_byte;
    logic multi_byte;

    assign single_byte = byte_cnt_ff == 3'h1 && bit_cnt_ff == 3'h0;
    assign multi_byte  = byte_cnt_ff >= host_link_pkg::BYTE_STATUS;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            host_command_byte <= 8'h00;
            command_irq       <= 1'b0;
        end else begin
            command_irq <= 1'b0;
            if (frame_end && single_byte) begin
                host_command_byte <= first_byte_ff;
                command_irq       <= 1'b1;
            end else if (frame_end && multi_byte && cmd_byte_ff[6:0] != host_link_pkg::CMD_NULL_LOW) begin
                host_command_byte <= cmd_byte_ff;
                command_irq       <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            host_link_status <= 8'h00;
        end else if (frame_end) begin
            host_link_status <= 8'h00;
            host_link_status[host_link_pkg::STAT_PARITY_BIT] <= parity_ff;
            host_link_status[host_link_pkg::STAT_ERROR_BIT]  <= not_ready_ff || bit_cnt_ff != 3'h0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            serial_pin_mode <= 1'b1;
        end else begin
            serial_pin_mode <= enabled;
        end
    end

endmodule

//--- shared/host_link_pkg.sv
// constants shared by both ends of the host serial memory port
package host_link_pkg;
    // device: byte index in a frame
    localparam logic [2:0]  BYTE_ADDR_HI   = 3'h0;
    localparam logic [2:0]  BYTE_CMD       = 3'h2;
    localparam logic [2:0]  BYTE_STATUS    = 3'h3;
    localparam logic [2:0]  BYTE_DATA0     = 3'h4;
    localparam logic [2:0]  BYTE_SAT       = 3'h7;
    localparam logic [2:0]  BIT_LAST       = 3'h7;
    localparam int          CMD_RW_BIT     = 7;
    localparam int          CMD_QUIET_BIT  = 6;
    localparam logic [6:0]  CMD_NULL_LOW   = 7'h00;
    // device: config and status fields
    localparam int          CFG_PROTECT_BIT = 3;
    localparam int          CFG_ENABLE_BIT  = 4;
    localparam int          STAT_PARITY_BIT = 0;
    localparam int          STAT_ERROR_BIT  = 1;
    localparam logic [15:0] STATUS_ADDR     = 16'h2708;
    localparam logic [15:0] CONFIG_ADDR     = 16'h270C;
    localparam logic [7:0]  CMD_REG_ADDR    = 8'hFD;
    localparam logic [15:0] OPEN_LO         = 16'h0400;
    localparam logic [15:0] OPEN_HI         = 16'h040F;
    // host: AXI4-Lite register map
    localparam logic [3:0]  REG_TX      = 4'h0;
    localparam logic [3:0]  REG_STATUS  = 4'h4;
    localparam logic [3:0]  REG_DIV     = 4'h8;
    localparam int          TX_END_BIT  = 8;
    localparam int          ST_BUSY_BIT = 8;
    localparam logic [7:0]  DIV_RESET   = 8'h04;
    localparam logic [1:0]  RESP_OKAY   = 2'b00;
    localparam logic [1:0]  RESP_SLVERR = 2'b10;
endpackage

//--- shared/host_link_if.sv
// serial link between the host controller and the device memory port
`timescale 1ns/1ps
interface host_link_if;
    logic select_n;
    logic sclk;
    logic mosi;
    logic miso;
    logic miso_oe_n;
    logic miso_line;

    // pulled high while the device floats its output
    assign miso_line = miso_oe_n ? 1'b1 : miso;

    modport device (input select_n, input sclk, input mosi, output miso, output miso_oe_n);
    modport host   (output select_n, output sclk, output mosi, input miso_line);
endinterface

//--- rtl/host_link_controller.sv
// host end: AXI4-Lite controlled serial master for the device memory port
`timescale 1ns/1ps
module host_link_controller (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    host_link_if.host        link,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic      [1:0]  s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic      [31:0] s_axi_rdata,
    output logic      [1:0]  s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_SETUP = 5'b00010,
        ST_LOW   = 5'b00100,
        ST_HIGH  = 5'b01000,
        ST_TAIL  = 5'b10000
    } phase_t;

    phase_t      state_ff;
    logic [7:0]  div_ff;
    logic [7:0]  cnt_ff;
    logic [7:0]  tx_ff;
    logic [7:0]  rx_ff;
    logic [2:0]  bit_ff;
    logic        end_ff;
    logic        sel_n_ff;
    logic        sclk_ff;
    logic        mosi_ff;
    logic        mi_s1_ff, mi_s2_ff;
    logic [3:0]  aw_ff;
    logic [31:0] w_ff;
    logic        start;

    ////////////////////
    // AXI4-Lite slave: address and data taken in either order

    assign start = s_axi_awready == 1'b0 && s_axi_wready == 1'b0 && !s_axi_bvalid
                   && aw_ff == host_link_pkg::REG_TX && state_ff == ST_IDLE && s_axi_wstrb[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= host_link_pkg::RESP_OKAY;
            aw_ff         <= 4'h0;
            w_ff          <= 32'h0000_0000;
            div_ff        <= host_link_pkg::DIV_RESET;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ff         <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ff         <= s_axi_wdata;
                s_axi_wready <= 1'b0;
            end
            if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= host_link_pkg::RESP_OKAY;
                if (aw_ff == host_link_pkg::REG_DIV) begin
                    if (s_axi_wstrb[0] && w_ff[7:0] != 8'h00) begin
                        div_ff <= w_ff[7:0];
                    end
                end else if (!start) begin
                    // busy, byte lane missing or unmapped
                    s_axi_bresp <= host_link_pkg::RESP_SLVERR;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= host_link_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= host_link_pkg::RESP_OKAY;
            s_axi_rdata   <= 32'h0000_0000;
            if (s_axi_araddr == host_link_pkg::REG_STATUS) begin
                s_axi_rdata[7:0]                      <= rx_ff;
                s_axi_rdata[host_link_pkg::ST_BUSY_BIT] <= state_ff != ST_IDLE;
            end else if (s_axi_araddr == host_link_pkg::REG_DIV) begin
                s_axi_rdata[7:0] <= div_ff;
            end else begin
                s_axi_rresp <= host_link_pkg::RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    ////////////////////
    // serial master: clock divided from aclk, one byte per order

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mi_s1_ff <= 1'b1;
            mi_s2_ff <= 1'b1;
        end else begin
            mi_s1_ff <= link.miso_line;
            mi_s2_ff <= mi_s1_ff;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= ST_IDLE;
            cnt_ff   <= 8'h00;
            tx_ff    <= 8'h00;
            rx_ff    <= 8'h00;
            bit_ff   <= 3'h0;
            end_ff   <= 1'b0;
            sel_n_ff <= 1'b1;
            sclk_ff  <= 1'b0;
            mosi_ff  <= 1'b0;
        end else begin
            cnt_ff <= cnt_ff + 8'h01;
            case (state_ff)
                ST_IDLE: begin
                    cnt_ff <= 8'h00;
                    if (start) begin
                        tx_ff    <= {w_ff[6:0], 1'b0};
                        mosi_ff  <= w_ff[7];
                        end_ff   <= w_ff[host_link_pkg::TX_END_BIT];
                        bit_ff   <= 3'h0;
                        sel_n_ff <= 1'b0;
                        state_ff <= ST_SETUP;
                    end
                end
                ST_SETUP, ST_LOW: begin
                    if (cnt_ff + 8'h01 >= div_ff) begin
                        cnt_ff   <= 8'h00;
                        sclk_ff  <= 1'b1;
                        state_ff <= ST_HIGH;
                    end
                end
                ST_HIGH: begin
                    if (cnt_ff + 8'h01 >= div_ff) begin
                        // sampled late in the high phase to absorb device latency
                        cnt_ff  <= 8'h00;
                        sclk_ff <= 1'b0;
                        rx_ff   <= {rx_ff[6:0], mi_s2_ff};
                        bit_ff  <= bit_ff + 3'h1;
                        if (bit_ff == 3'h7) begin
                            state_ff <= end_ff ? ST_TAIL : ST_IDLE;
                        end else begin
                            mosi_ff  <= tx_ff[7];
                            tx_ff    <= {tx_ff[6:0], 1'b0};
                            state_ff <= ST_LOW;
                        end
                    end
                end
                ST_TAIL: begin
                    if (cnt_ff + 8'h01 >= div_ff) begin
                        sel_n_ff <= 1'b1;
                        state_ff <= ST_IDLE;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    assign link.select_n = sel_n_ff;
    assign link.sclk     = sclk_ff;
    assign link.mosi     = mosi_ff;

endmodule

//--- testbench/host_link_assertions.sv
// link checks between the host controller and the device port
`timescale 1ns/1ps
module host_link_assertions (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic select_n,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic miso_oe_n,
    input wire logic miso_line
);
    logic [5:0] bits_ff;
    logic       sclk_ff;
    ////////////////////////////////////////
    // rising link clocks seen in the current frame
    always_ff @(posedge aclk) begin
        if (!aresetn || select_n) begin
            bits_ff <= 6'h00;
        end else if (sclk && !sclk_ff) begin
            bits_ff <= bits_ff + 6'h01;
        end
    end
    always_ff @(posedge aclk) begin
        sclk_ff <= sclk;
    end
    ////////////////////////////////////////
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // counts assume the reset divider of 4
    sequence s_lead; !sclk[*3]; endsequence
    sequence s_high; sclk[*4] ##1 !sclk; endsequence
    property p_float_idle; select_n[*6] |-> miso_oe_n && miso_line; endproperty
    property p_sclk_idle; select_n |-> !sclk; endproperty
    property p_lead; $fell(select_n) |-> s_lead; endproperty
    property p_half; $rose(sclk) |-> s_high; endproperty
    property p_mosi; sclk && $past(sclk) |-> $stable(mosi); endproperty
    property p_miso; !select_n && sclk && $past(sclk, 3) && $past(sclk, 2) && $past(sclk) |-> $stable(miso_line);
    endproperty
    property p_sel_edge; $changed(select_n) |-> !sclk && !$past(sclk); endproperty
    property p_bytes; $rose(select_n) |-> bits_ff[2:0] == 3'h0; endproperty
    a_float_idle: assert property (p_float_idle) else $error("driven idle");
    a_sclk_idle: assert property (p_sclk_idle) else $error("clock idle high");
    a_lead: assert property (p_lead) else $error("early clock");
    a_half: assert property (p_half) else $error("bad high phase");
    a_mosi: assert property (p_mosi) else $error("mosi moved");
    a_miso: assert property (p_miso) else $error("miso moved");
    a_sel_edge: assert property (p_sel_edge) else $error("select moved");
    a_bytes: assert property (p_bytes) else $error("partial byte");
endmodule

//--- testbench/tb_top.sv
// bench: host controller driving the device port across the serial link
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {
        logic [7:0]  cfg;
        logic [15:0] addr;
        logic [7:0]  cmd;
        logic [7:0]  data;
        logic [7:0]  exp_mem;
        logic [7:0]  exp_cmd;
        logic [1:0]  exp_ci;
        logic [1:0]  exp_wi;
    } row_t;
    logic        aclk = 1'b0, aresetn = 1'b0, dev_ready = 1'b1, err_now = 1'b0;
    logic        mem_we, mem_re, cmd_irq, wr_irq, pin_mode;
    logic [7:0]  cfg_byte = 8'h10, mem_rdata = 8'h00, exp_stat = 8'h00;
    logic [7:0]  mem_wdata, cmd_byte, link_stat;
    logic [15:0] mem_addr, ci = 16'h0, wi = 16'h0;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [7:0]  mem [0:65535];
    logic [7:0]  tx_q [$];
    logic [7:0]  rx_q [$];
    int          fails = 0, checks_done = 0;
    row_t        rows [0:6];
    host_link_if link ();
    host_serial_slave_memory_port i_host_serial_slave_memory_port (.aclk, .aresetn, .link(link.device),
        .config_byte(cfg_byte), .device_ready(dev_ready), .mem_addr, .mem_wdata, .mem_we, .mem_re, .mem_rdata,
        .host_command_byte(cmd_byte), .host_link_status(link_stat), .command_irq(cmd_irq), .write_irq(wr_irq),
        .serial_pin_mode(pin_mode));
    host_link_controller i_host_link_controller (.aclk, .aresetn, .link(link.host), .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    host_link_assertions i_host_link_assertions (.aclk, .aresetn, .select_n(link.select_n), .sclk(link.sclk),
        .mosi(link.mosi), .miso_oe_n(link.miso_oe_n), .miso_line(link.miso_line));
    ////////////////////////////////////////
    // memory with one-cycle read latency, and irq pulse counts
    always @(posedge aclk) begin
        if (mem_re) mem_rdata <= mem[mem_addr];
        if (mem_we) mem[mem_addr] <= mem_wdata;
        if (cmd_irq === 1'b1) ci = ci + 16'h1;
        if (wr_irq === 1'b1) wi = wi + 16'h1;
    end
    initial begin
        forever #20 aclk = ~aclk;
    end
    initial begin
        repeat (40000) @(posedge aclk);
        fails++;
        print_verdict;
    end
    ////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic axi_w(input logic [3:0] a, input logic [31:0] v, output logic [1:0] resp);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
        while (s_axi_bvalid !== 1'b1) @(posedge aclk);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_r(input logic [3:0] a, output logic [31:0] v, output logic [1:0] resp);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) @(posedge aclk);
        v = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic run_frame;
        logic p;
        p = 1'b0;
        ci = 16'h0;
        wi = 16'h0;
        rx_q = {};
        foreach (tx_q[i]) begin
            axi_w(host_link_pkg::REG_TX, {23'h0, i == tx_q.size() - 1, tx_q[i]}, r);
            do axi_r(host_link_pkg::REG_STATUS, d, r); while (d[host_link_pkg::ST_BUSY_BIT] !== 1'b0);
            rx_q.push_back(d[7:0]);
            p = p ^ (^tx_q[i]);
        end
        repeat (12) @(posedge aclk);
        if (cfg_byte[host_link_pkg::CFG_ENABLE_BIT]) begin
            if (rx_q.size() > 3) check(rx_q[3], exp_stat, "stb");
            exp_stat = {6'h00, err_now, p};
            check(link_stat, exp_stat, "str");
        end
    endtask
    task automatic do_reset;
        aresetn <= 1'b0;
        repeat (10) @(posedge aclk);
        check(pin_mode, 1'b1, "rpm");
        check(link.miso_oe_n, 1'b1, "roe");
        check(cmd_byte, 8'h00, "rcmd");
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        exp_stat = 8'h00;
        $display("reset test done");
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        foreach (mem[j]) mem[j] = 8'h00;
        mem[16'h0101] = 8'hC3;
        mem[16'h0410] = 8'hEE;
        // config, address, command, data, memory after, command after, irq counts
        rows = '{'{8'h10, 16'h0100, 8'h00, 8'h5A, 8'h5A, 8'h00, 2'h0, 2'h1},
                 '{8'h10, 16'h0101, 8'h80, 8'h00, 8'hC3, 8'h00, 2'h0, 2'h0},
                 '{8'h10, 16'h0200, 8'h05, 8'h33, 8'h33, 8'h05, 2'h1, 2'h1},
                 '{8'h10, 16'h0201, 8'h45, 8'h44, 8'h44, 8'h45, 2'h1, 2'h0},
                 '{8'h18, 16'h040F, 8'h00, 8'h77, 8'h77, 8'h45, 2'h0, 2'h1},
                 '{8'h18, 16'h0410, 8'h00, 8'h66, 8'hEE, 8'h45, 2'h0, 2'h0},
                 '{8'h18, 16'h0410, 8'h81, 8'h00, 8'hEE, 8'h81, 2'h1, 2'h0}};
        do_reset;
        foreach (rows[k]) begin
            cfg_byte <= rows[k].cfg;
            tx_q = {rows[k].addr[15:8], rows[k].addr[7:0], rows[k].cmd, 8'h00, rows[k].data};
            run_frame;
            check(mem[rows[k].addr], rows[k].exp_mem, "mem");
            if (rows[k].cmd[7]) check(rx_q[4], rows[k].exp_mem, "rd");
            check(cmd_byte, rows[k].exp_cmd, "cmd");
            check(ci, rows[k].exp_ci, "ci");
            check(wi, rows[k].exp_wi, "wi");
            $display("row %0d done", k);
        end
        tx_q = {8'h01, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00};
        run_frame;
        check(rx_q[4], 8'h5A, "rd0");
        check(rx_q[5], 8'hC3, "rd1");
        $display("increment test done");
        // command requests read
        // not ready through a lone command byte, error shows in the next frame
        dev_ready <= 1'b0;
        err_now = 1'b1;
        tx_q = {8'h80};
        run_frame;
        check(cmd_byte, 8'h80, "scmd");
        check(ci, 16'h1, "sci");
        dev_ready <= 1'b1;
        err_now = 1'b0;
        tx_q = {8'h01, 8'h00, 8'h80, 8'h00, 8'h00};
        run_frame;
        check(rx_q[3][host_link_pkg::STAT_ERROR_BIT], 1'b1, "err");
        $display("error test done");
        axi_r(4'hC, d, r);
        check(r, host_link_pkg::RESP_SLVERR, "ures");
        check(d[15:0], 16'h0, "udat");
        axi_w(host_link_pkg::REG_DIV, 32'h0, r);
        axi_r(host_link_pkg::REG_DIV, d, r);
        check(d[7:0], host_link_pkg::DIV_RESET, "div");
        $display("register test done");
        cfg_byte <= 8'h00;
        tx_q = {8'h03, 8'h00, 8'h00, 8'h00, 8'h11};
        run_frame;
        check(mem[16'h0300], 8'h00, "dwr");
        check(wi, 16'h0, "dwi");
        check(pin_mode, 1'b0, "dpm");
        do_reset;
        print_verdict;
    end
endmodule
